// ---- inc/cfgsl_params.svh ----
// Purpose: Constants for the synthesizer configuration slave.
// Assumes: Included by the top-level design file by bare name; the package does not include it.
// Notes:   Timing is event driven from sampled pins; no long counts are needed.
`ifndef CFGSL_PARAMS_SVH
`define CFGSL_PARAMS_SVH

`define CFGSL_SLAVE_ADDR7   7'h69
`define CFGSL_OFS_CTRL0     7'h00
`define CFGSL_NUM_BYTES     8'h01
`define CFGSL_CTRL0_RST     8'h01
`define CFGSL_CTRL0_WMASK   8'h17
`define CFGSL_BIT_MGMT      4
`define CFGSL_BIT_MAINSRC   2
`define CFGSL_BIT_STORSEL   1
`define CFGSL_BIT_RETAIN    0
`define CFGSL_CMD_SINGLE    7
`define CFGSL_FIFO_DEPTH    8
`define CFGSL_FIFO_WIDTH    15
`define CFGSL_MHZ_266       9'h10a
`define CFGSL_MHZ_133       9'h085
`define CFGSL_MHZ_200       9'h0c8
`define CFGSL_MHZ_166       9'h0a6
`define CFGSL_MHZ_333       9'h14d
`define CFGSL_MHZ_100       9'h064
`define CFGSL_MHZ_400       9'h190
`define CFGSL_CODE_RSVD     3'h7

`endif

// ---- inc/cfgsl_pkg.sv ----
// Purpose: Types shared by the configuration slave files.
// Assumes: Takes no constants from cfgsl_params.svh; the state codes are literals.
// Notes:   Slave states are Gray coded along the write byte path; SACK to TX changes two bits.
package cfgsl_pkg;
  typedef enum logic [2:0] {
    CFGSL_IDLE = 3'h0,
    CFGSL_ADDR = 3'h1,
    CFGSL_SACK = 3'h3,
    CFGSL_RX   = 3'h2,
    CFGSL_TX   = 3'h6,
    CFGSL_MACK = 3'h7,
    CFGSL_IGN  = 3'h5
  } cfgsl_state_e;
  typedef enum logic [1:0] {
    CFGSL_PH_CMD   = 2'h0,
    CFGSL_PH_COUNT = 2'h1,
    CFGSL_PH_DATA  = 2'h2,
    CFGSL_PH_DONE  = 2'h3
  } cfgsl_phase_e;
endpackage

// ---- core/cfgsl_fifo.sv ----
// Purpose: Small FIFO holding received register writes.
// Assumes: One clock; push and pop handshake with valid and ready.
// Notes:   Pointers carry one extra bit so full and empty are exact.
`timescale 1ns/1ps
module cfgsl_fifo #(
  parameter int W = 15,
  parameter int D = 8
) (
  input  wire logic         clk_i,       // System clock.
  input  wire logic         rst_i,       // Asynchronous reset, active high.
  input  wire logic         in_valid_i,  // Write word offered.
  output logic              in_ready_o,  // Room for a word.
  input  wire logic [W-1:0] in_data_i,   // Write word.
  output logic              out_valid_o, // Word available.
  input  wire logic         out_ready_i, // Drain side takes the word.
  output logic [W-1:0]      out_data_o   // Oldest word.
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem_q [D];
  logic [AW:0]  wp_q, wp_d, rp_q, rp_d;
  logic         push, pop;

  always_comb begin
    in_ready_o  = (wp_q[AW] == rp_q[AW]) || (wp_q[AW-1:0] != rp_q[AW-1:0]);
    out_valid_o = (wp_q != rp_q);
    out_data_o  = mem_q[rp_q[AW-1:0]];
    push        = in_valid_i && in_ready_o;
    pop         = out_valid_o && out_ready_i;
    wp_d        = push ? wp_q + 1'b1 : wp_q;
    rp_d        = pop ? rp_q + 1'b1 : rp_q;
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      wp_q <= '0;
      rp_q <= '0;
    end else begin
      wp_q <= wp_d;
      rp_q <= rp_d;
    end
  end

  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_q[wp_q[AW-1:0]] <= in_data_i;
    end
  end
endmodule // cfgsl_fifo

// ---- core/cfgsl_top.sv ----
// Purpose: Strap latch and serial configuration slave of a clock synthesizer.
// Assumes: Pins are asynchronous to mclk_i and pass two flip-flops first.
// Notes:   The serial clock is sampled at 125 MHz, never used as a clock.
// How it works
// - Decode latched straps into CPU frequency
// - Capture straps when power-good sampled high
// - Capture once, except while in test mode
// - Control registers load defaults at reset
// - Byte and block, read and write
// - Block walks ascending, MSB first, stops anywhere
// - Answer only to address D2h
// - Command bit 7 selects single or block
// - Block write: command, count, acked data
// - Block read: count then data, NACK ends
// - Single write stores only the indexed byte
// - Single read returns one byte, NACKed
// - Byte 0 bits 7:5 show latched straps
// - Bit 4 management mode, by write or pins
// - Bit 2 selects main reference source
// - Bit 1 selects storage-link clock source
// - Bit 0 keeps config across power-down
// - After power-good, pin low means power-down
// - Strap C high at capture enters test
`timescale 1ns/1ps
`include "cfgsl_params.svh"
module cfgsl_top
  import cfgsl_pkg::*;
(
  input  wire logic mclk_i,                      // 125 MHz clock.
  input  wire logic sys_rst_i,                   // Asynchronous reset, active high.
  input  wire logic smb_clk_i,                   // Serial clock pin.
  input  wire logic smb_data_i,                  // Serial data pin level.
  output logic      smb_data_o,                  // Serial data drive value, always low.
  output logic      smb_data_oe_n_o,             // Low while pulling data low.
  input  wire logic power_good_strobe_i,         // Power-good, later power_down_n.
  input  wire logic freq_strap_a_i,              // Frequency strap A.
  input  wire logic freq_strap_b_i,              // Frequency strap B.
  input  wire logic freq_strap_c_i,              // Frequency strap C.
  input  wire logic cpu_clock_stop_n_i,          // CPU clock stop, active low.
  input  wire logic pci_clock_stop_n_i,          // PCI clock stop, active low.
  output logic      latched_freq_bit_a_o,        // Latched strap A.
  output logic      latched_freq_bit_b_o,        // Latched strap B.
  output logic      latched_freq_bit_c_o,        // Latched strap C.
  output logic      straps_captured_o,           // Strap capture has happened.
  output logic      test_mode_o,                 // Test mode active.
  output logic [8:0] cpu_freq_mhz_o,             // Selected CPU frequency in MHz.
  output logic      cpu_freq_reserved_o,         // Reserved strap code.
  output logic      power_down_req_o,            // Real-time power-down request.
  output logic      mgmt_mode_enable_o,          // Management mode.
  output logic      main_refclk_source_select_o, // Main reference source select.
  output logic      storage_link_clock_select_o, // Storage-link clock select.
  output logic      retain_config_on_powerdown_o // Keep config on power-down.
);
  function automatic logic [8:0] mhz_of(input logic [2:0] code);
    case (code)
      3'h0:    mhz_of = `CFGSL_MHZ_266;
      3'h1:    mhz_of = `CFGSL_MHZ_133;
      3'h2:    mhz_of = `CFGSL_MHZ_200;
      3'h3:    mhz_of = `CFGSL_MHZ_166;
      3'h4:    mhz_of = `CFGSL_MHZ_333;
      3'h5:    mhz_of = `CFGSL_MHZ_100;
      3'h6:    mhz_of = `CFGSL_MHZ_400;
      default: mhz_of = 9'h000;
    endcase
  endfunction

  // Two-flop synchronisers; the third serial stage only feeds edge detection.
  logic       scl_m_q, scl_s_q, scl_p_q, sda_m_q, sda_s_q, sda_p_q;
  logic       pg_m_q, pg_s_q, cs_m_q, cs_s_q, ps_m_q, ps_s_q;
  logic [2:0] st_m_q, st_s_q;
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      {scl_m_q, scl_s_q, scl_p_q, sda_m_q, sda_s_q, sda_p_q} <= 6'h3f;
      {pg_m_q, pg_s_q}                                       <= 2'h0;
      {cs_m_q, cs_s_q, ps_m_q, ps_s_q}                       <= 4'hf;
      st_m_q                                                 <= 3'h0;
      st_s_q                                                 <= 3'h0;
    end else begin
      {scl_m_q, scl_s_q, scl_p_q} <= {smb_clk_i, scl_m_q, scl_s_q};
      {sda_m_q, sda_s_q, sda_p_q} <= {smb_data_i, sda_m_q, sda_s_q};
      {pg_m_q, pg_s_q}            <= {power_good_strobe_i, pg_m_q};
      {cs_m_q, cs_s_q}            <= {cpu_clock_stop_n_i, cs_m_q};
      {ps_m_q, ps_s_q}            <= {pci_clock_stop_n_i, ps_m_q};
      st_m_q <= {freq_strap_c_i, freq_strap_b_i, freq_strap_a_i};
      st_s_q <= st_m_q;
    end
  end
  logic scl_rise, scl_fall, bus_start, bus_stop;
  assign scl_rise  = scl_s_q && !scl_p_q;
  assign scl_fall  = !scl_s_q && scl_p_q;
  assign bus_start = scl_s_q && scl_p_q && sda_p_q && !sda_s_q;
  assign bus_stop  = scl_s_q && scl_p_q && !sda_p_q && sda_s_q;

  // Strap latch, test mode and the power-down pin.
  logic       cap_q, cap_d, test_q, test_d, pd_q, pd_d, rsv_q, rsv_d;
  logic [2:0] lat_q, lat_d;
  logic [8:0] mhz_q, mhz_d;
  always_comb begin
    cap_d  = cap_q;
    lat_d  = lat_q;
    test_d = test_q;
    if (pg_s_q && (!cap_q || test_q)) begin
      cap_d = 1'b1;
      lat_d = st_s_q;
      if (!cap_q) begin
        test_d = st_s_q[2];
      end
    end
    pd_d  = cap_q && !pg_s_q;
    mhz_d = mhz_of(lat_q);
    rsv_d = (lat_q == `CFGSL_CODE_RSVD);
  end
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cap_q  <= 1'b0;
      lat_q  <= 3'h0;
      test_q <= 1'b0;
      pd_q   <= 1'b0;
      mhz_q  <= 9'h000;
      rsv_q  <= 1'b0;
    end else begin
      cap_q  <= cap_d;
      lat_q  <= lat_d;
      test_q <= test_d;
      pd_q   <= pd_d;
      mhz_q  <= mhz_d;
      rsv_q  <= rsv_d;
    end
  end

  // Write FIFO; writes are held while power-down is requested, so it can fill.
  logic                        f_in_valid, f_in_ready, f_out_valid, f_out_ready;
  logic [`CFGSL_FIFO_WIDTH-1:0] f_in_data, f_out_data;
  assign f_out_ready = !pd_q;
  cfgsl_fifo #(.W(`CFGSL_FIFO_WIDTH), .D(`CFGSL_FIFO_DEPTH)) u_fifo (
    .clk_i       (mclk_i),
    .rst_i       (sys_rst_i),
    .in_valid_i  (f_in_valid),
    .in_ready_o  (f_in_ready),
    .in_data_i   (f_in_data),
    .out_valid_o (f_out_valid),
    .out_ready_i (f_out_ready),
    .out_data_o  (f_out_data)
  );

  // Control byte 0; bits 7:5 and 3 are never stored.
  logic [7:0] ctrl_q, ctrl_d;
  always_comb begin
    ctrl_d = ctrl_q;
    if (pd_d && !pd_q && !ctrl_q[`CFGSL_BIT_RETAIN]) begin
      ctrl_d = `CFGSL_CTRL0_RST;
    end
    if (f_out_valid && f_out_ready && f_out_data[14:8] == `CFGSL_OFS_CTRL0) begin
      ctrl_d = f_out_data[7:0] & `CFGSL_CTRL0_WMASK;
    end
    if (pd_q && !cs_s_q && !ps_s_q) begin
      ctrl_d[`CFGSL_BIT_MGMT] = 1'b1;
    end
  end
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ctrl_q <= `CFGSL_CTRL0_RST;
    end else begin
      ctrl_q <= ctrl_d;
    end
  end
  logic [7:0] byte0;
  assign byte0 = {lat_q, ctrl_q[4], 1'b0, ctrl_q[2:0]};

  // Serial slave.
  cfgsl_state_e st_q, st_d;
  cfgsl_phase_e ph_q, ph_d;
  logic [3:0]   bits_q, bits_d;
  logic [7:0]   sh_q, sh_d, nxt_byte;
  logic [6:0]   idx_q, idx_d;
  logic         rw_q, rw_d, blk_q, blk_d, ack_q, ack_d, cnt_q, cnt_d, oe_n_q, oe_n_d;
  always_comb begin
    st_d = st_q; ph_d = ph_q; bits_d = bits_q; sh_d = sh_q; idx_d = idx_q;
    rw_d = rw_q; blk_d = blk_q; ack_d = ack_q; cnt_d = cnt_q; oe_n_d = oe_n_q;
    f_in_valid = 1'b0;
    f_in_data  = {idx_q, sh_q};
    nxt_byte   = (blk_q && !cnt_q) ? `CFGSL_NUM_BYTES :
                 ((idx_q == `CFGSL_OFS_CTRL0) ? byte0 : 8'h00);
    if (bus_stop) begin
      st_d = CFGSL_IDLE; ph_d = CFGSL_PH_CMD; oe_n_d = 1'b1;
    end else if (bus_start) begin
      // A repeated start keeps the command so a read can follow it.
      st_d = CFGSL_ADDR; bits_d = 4'h0; oe_n_d = 1'b1; cnt_d = 1'b0;
      if (st_q == CFGSL_IDLE || st_q == CFGSL_IGN) begin
        ph_d = CFGSL_PH_CMD;
      end
    end else begin
      case (st_q)
        CFGSL_ADDR, CFGSL_RX: begin
          if (scl_rise) begin
            sh_d = {sh_q[6:0], sda_s_q};
            bits_d = bits_q + 4'h1;
          end else if (scl_fall && bits_q == 4'h8) begin
            st_d = CFGSL_SACK;
            oe_n_d = 1'b0;
            if (st_q == CFGSL_ADDR) begin
              rw_d = sh_q[0];
              if (sh_q[7:1] != `CFGSL_SLAVE_ADDR7) begin
                st_d = CFGSL_IGN; oe_n_d = 1'b1;
              end
            end else begin
              case (ph_q)
                CFGSL_PH_CMD: begin
                  blk_d = !sh_q[`CFGSL_CMD_SINGLE];
                  idx_d = sh_q[`CFGSL_CMD_SINGLE] ? sh_q[6:0] : 7'h00;
                  ph_d  = sh_q[`CFGSL_CMD_SINGLE] ? CFGSL_PH_DATA : CFGSL_PH_COUNT;
                end
                CFGSL_PH_COUNT: ph_d = CFGSL_PH_DATA;
                CFGSL_PH_DATA: begin
                  if (f_in_ready) begin
                    f_in_valid = 1'b1;
                    idx_d = blk_q ? idx_q + 7'h01 : idx_q;
                    ph_d  = blk_q ? CFGSL_PH_DATA : CFGSL_PH_DONE;
                  end else begin
                    st_d = CFGSL_IGN; oe_n_d = 1'b1;
                  end
                end
                default: begin
                  st_d = CFGSL_IGN; oe_n_d = 1'b1;
                end
              endcase
            end
          end
        end
        CFGSL_SACK: begin
          if (scl_fall) begin
            if (rw_q) begin
              st_d = CFGSL_TX; sh_d = nxt_byte; oe_n_d = nxt_byte[7]; bits_d = 4'h0;
              if (blk_q && !cnt_q) cnt_d = 1'b1;
              else if (blk_q) idx_d = idx_q + 7'h01;
            end else begin
              st_d = CFGSL_RX; oe_n_d = 1'b1; bits_d = 4'h0;
            end
          end
        end
        CFGSL_TX: begin
          if (scl_fall) begin
            if (bits_q == 4'h7) begin
              st_d = CFGSL_MACK; oe_n_d = 1'b1;
            end else begin
              sh_d = {sh_q[6:0], 1'b0}; oe_n_d = sh_q[6]; bits_d = bits_q + 4'h1;
            end
          end
        end
        CFGSL_MACK: begin
          if (scl_rise) begin
            ack_d = !sda_s_q;
          end else if (scl_fall) begin
            if (ack_q && blk_q) begin
              st_d = CFGSL_TX; sh_d = nxt_byte; oe_n_d = nxt_byte[7]; bits_d = 4'h0;
              if (!cnt_q) cnt_d = 1'b1;
              else idx_d = idx_q + 7'h01;
            end else begin
              st_d = CFGSL_IGN;
            end
          end
        end
        CFGSL_IDLE, CFGSL_IGN: ;
        default: st_d = CFGSL_IDLE;
      endcase
    end
  end
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      st_q <= CFGSL_IDLE; ph_q <= CFGSL_PH_CMD; bits_q <= 4'h0; sh_q <= 8'h00;
      idx_q <= 7'h00; rw_q <= 1'b0; blk_q <= 1'b0; ack_q <= 1'b0; cnt_q <= 1'b0;
      oe_n_q <= 1'b1;
    end else begin
      st_q <= st_d; ph_q <= ph_d; bits_q <= bits_d; sh_q <= sh_d;
      idx_q <= idx_d; rw_q <= rw_d; blk_q <= blk_d; ack_q <= ack_d; cnt_q <= cnt_d;
      oe_n_q <= oe_n_d;
    end
  end

  assign smb_data_o                   = 1'b0;
  assign smb_data_oe_n_o              = oe_n_q;
  assign {latched_freq_bit_c_o, latched_freq_bit_b_o, latched_freq_bit_a_o} = lat_q;
  assign straps_captured_o            = cap_q;
  assign test_mode_o                  = test_q;
  assign cpu_freq_mhz_o               = mhz_q;
  assign cpu_freq_reserved_o          = rsv_q;
  assign power_down_req_o             = pd_q;
  assign mgmt_mode_enable_o           = ctrl_q[`CFGSL_BIT_MGMT];
  assign main_refclk_source_select_o  = ctrl_q[`CFGSL_BIT_MAINSRC];
  assign storage_link_clock_select_o  = ctrl_q[`CFGSL_BIT_STORSEL];
  assign retain_config_on_powerdown_o = ctrl_q[`CFGSL_BIT_RETAIN];

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (sys_rst_i);

  // The first edge after release still sees the reset value, so it is skipped.
  a_freq_decode: assert property (!$past(sys_rst_i) |-> mhz_q == mhz_of($past(lat_q)))
    else $error("CPU frequency does not match latched straps");
  a_strap_capture: assert property (!cap_q && pg_s_q |=>
      cap_q && lat_q == $past(st_s_q))
    else $error("Straps not captured on power-good");
  a_strap_oneshot: assert property (cap_q && !test_q |=> $stable(lat_q) && cap_q)
    else $error("Latched straps changed outside test mode");
  a_test_entry: assert property (!cap_q && pg_s_q |=> test_q == $past(st_s_q[2]))
    else $error("Test mode entry wrong");
  a_pd_request: assert property (pd_q |-> cap_q && $past(!pg_s_q))
    else $error("Power-down request without capture or pin low");
  a_reserved_bits: assert property (byte0[3] == 1'b0 && ctrl_q[7:5] == 3'h0)
    else $error("Reserved or strap bits stored from a write");
  a_foreign_addr: assert property (st_q == CFGSL_IGN |-> oe_n_q)
    else $error("Data driven during ignored transaction");
  a_cmd_class: assert property (st_q == CFGSL_RX && ph_q == CFGSL_PH_CMD && scl_fall
      && bits_q == 4'h8 && !bus_start && !bus_stop |=> blk_q == !$past(sh_q[7]))
    else $error("Command class decoded wrongly");
  a_block_ascend: assert property (f_in_valid && f_in_ready && blk_q |=>
      idx_q == $past(idx_q) + 7'h01)
    else $error("Block write index did not advance");
  a_retain_clear: assert property (pd_d && !pd_q && !ctrl_q[0] && !f_out_valid
      && !(pd_q && !cs_s_q && !ps_s_q) |=> ctrl_q == `CFGSL_CTRL0_RST)
    else $error("Config not cleared on power-down");

  c_block_write: cover property (f_in_valid && blk_q ##[1:1000] f_in_valid && blk_q);
  c_block_read: cover property (st_q == CFGSL_TX && blk_q && cnt_q && idx_q == 7'h00);
  c_single_read: cover property (st_q == CFGSL_MACK && !blk_q ##[1:300] st_q == CFGSL_IGN);
  c_test_mode: cover property (test_q && $changed(lat_q));
endmodule // cfgsl_top

// ---- bench/cfgsl_smb_master.sv ----
// Purpose: Behavioural system controller acting as master on the serial pins.
// Assumes: The data line has a pull-up; pull_o high means this side pulls it low.
// Notes:   Clock period is 125 ns and the clock stands high between frames.
`timescale 1ns/1ps
module cfgsl_smb_master (
  input  wire logic sda_i,  // Resolved data line level.
  output logic      scl_o,  // Serial clock.
  output logic      pull_o  // High while pulling data low.
);
  localparam real QTR = 31.25;

  initial begin
    scl_o = 1'b1;
    pull_o = 1'b0;
  end

  // Serves as start and as repeated start.
  task automatic start_c();
    #QTR pull_o = 1'b0;
    #QTR scl_o = 1'b1;
    #QTR pull_o = 1'b1;
    #QTR scl_o = 1'b0;
  endtask

  task automatic stop_c();
    #QTR pull_o = 1'b1;
    #QTR scl_o = 1'b1;
    #QTR pull_o = 1'b0;
    #QTR;
  endtask

  task automatic bit_x(input logic b, output logic s);
    #QTR pull_o = ~b;
    #QTR scl_o = 1'b1;
    #QTR s = sda_i;
    #QTR scl_o = 1'b0;
  endtask

  task automatic xfer(input logic [7:0] tx, input logic ab, output logic [7:0] rx,
                      output logic nack);
    for (int i = 7; i >= 0; i--) bit_x(tx[i], rx[i]);
    bit_x(ab, nack);
  endtask

  task automatic byte_write(input logic [7:0] ad, cmd, dat, output logic [2:0] nk);
    logic [7:0] rx;
    start_c();
    xfer(ad, 1'b1, rx, nk[2]);
    xfer(cmd, 1'b1, rx, nk[1]);
    xfer(dat, 1'b1, rx, nk[0]);
    stop_c();
  endtask

  task automatic byte_read(input logic [7:0] ad, cmd, output logic [7:0] dat,
                           output logic [2:0] nk);
    logic n;
    start_c();
    xfer(ad, 1'b1, dat, nk[2]);
    xfer(cmd, 1'b1, dat, nk[1]);
    start_c();
    xfer(ad | 8'h01, 1'b1, dat, nk[0]);
    xfer(8'hff, 1'b1, dat, n);
    stop_c();
  endtask

  task automatic blk_write(input logic [7:0] ad, cnt, dat, output logic [3:0] nk);
    logic [7:0] rx;
    start_c();
    xfer(ad, 1'b1, rx, nk[3]);
    xfer(8'h00, 1'b1, rx, nk[2]);
    xfer(cnt, 1'b1, rx, nk[1]);
    xfer(dat, 1'b1, rx, nk[0]);
    stop_c();
  endtask

  // The last byte read gets a not-acknowledge so the slave lets go of the line.
  task automatic blk_read(input logic [7:0] ad, output logic [7:0] d [3]);
    logic n;
    start_c();
    xfer(ad, 1'b1, d[0], n);
    xfer(8'h00, 1'b1, d[0], n);
    start_c();
    xfer(ad | 8'h01, 1'b1, d[0], n);
    for (int i = 0; i < 3; i++) xfer(8'hff, i == 2, d[i], n);
    stop_c();
  endtask
endmodule // cfgsl_smb_master

// ---- bench/cfgsl_top_tb.sv ----
// Purpose: Self-checking bench for the strap latch and configuration slave.
// Assumes: The master model drives the serial pins; the data line has a pull-up.
// Notes:   Expected values come from a small model kept in this bench.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin fail_count++; \
  $display("mismatch %s exp %h got %h", nm, e, g); end end
module cfgsl_top_tb;
  logic        mclk = 1'b0;
  logic        rst = 1'b1;
  logic        pg = 1'b0;
  logic [2:0]  strap = 3'h0;
  logic        cpu_clock_stop_n = 1'b1;
  logic        pci_clock_stop_n = 1'b1;
  logic        scl, mpull, sda, oe_n, lat_a, lat_b, lat_c, capd, tmode, rsvd, pdreq;
  logic        mgmt, msrc, ssel, rtn;
  logic [8:0]  freq;
  logic [31:0] rs = 32'd23;
  logic [7:0]  exp0, d, rb;
  logic [7:0]  blk [3];
  logic [7:0]  pend [$];
  logic [2:0]  nk, code;
  logic [3:0]  nk4;
  int          fail_count = 0;
  int          n_compared = 0;
  int          ftab [8] = '{266, 133, 200, 166, 333, 100, 400, 0};

  always #4 mclk = ~mclk;
  // Pull-up: the line is high unless one party pulls it low.
  assign sda = ~(mpull | ~oe_n);

  cfgsl_top DUT (
    .mclk_i(mclk), .sys_rst_i(rst), .smb_clk_i(scl), .smb_data_i(sda), .smb_data_o(),
    .smb_data_oe_n_o(oe_n), .power_good_strobe_i(pg), .freq_strap_a_i(strap[0]),
    .freq_strap_b_i(strap[1]), .freq_strap_c_i(strap[2]), .cpu_clock_stop_n_i(cpu_clock_stop_n),
    .pci_clock_stop_n_i(pci_clock_stop_n), .latched_freq_bit_a_o(lat_a), .latched_freq_bit_b_o(lat_b),
    .latched_freq_bit_c_o(lat_c), .straps_captured_o(capd), .test_mode_o(tmode),
    .cpu_freq_mhz_o(freq), .cpu_freq_reserved_o(rsvd), .power_down_req_o(pdreq),
    .mgmt_mode_enable_o(mgmt), .main_refclk_source_select_o(msrc),
    .storage_link_clock_select_o(ssel), .retain_config_on_powerdown_o(rtn));

  cfgsl_smb_master u_m (.sda_i(sda), .scl_o(scl), .pull_o(mpull));

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask

  task automatic wrap_up();
    if (fail_count == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic do_reset();
    rst <= 1'b1;
    pg <= 1'b0;
    cyc(4);
    rst <= 1'b0;
    cyc(5);
  endtask

  task automatic chk_regs();
    cyc(12);
    `CHK("mgmt", exp0[4], mgmt)
    `CHK("mainsrc", exp0[2], msrc)
    `CHK("storsel", exp0[1], ssel)
    `CHK("retain", exp0[0], rtn)
    u_m.byte_read(8'hd2, 8'h80, rb, nk);
    `CHK("rd_ack", 3'h0, nk)
    `CHK("byte0", exp0, rb)
    cyc(1);
  endtask

  initial begin
    cyc(100000);
    fail_count++;
    wrap_up();
  end

  initial begin
    for (int k = 0; k < 8; k++) begin
      code = 3'(k);
      do_reset();
      `CHK("capd0", 1'b0, capd)
      strap <= code;
      cyc(4);
      pg <= 1'b1;
      cyc(6);
      `CHK("latched", code, {lat_c, lat_b, lat_a})
      `CHK("freq", 9'(ftab[k]), freq)
      `CHK("reserved", code == 3'h7, rsvd)
      `CHK("testmode", code[2], tmode)
      rs = xs(rs);
      strap <= rs[2:0];
      cyc(6);
      `CHK("oneshot", code[2] ? rs[2:0] : code, {lat_c, lat_b, lat_a})
      pg <= 1'b0;
      cyc(6);
      `CHK("pdreq", 1'b1, pdreq)
    end
    rs = xs(rs);
    code = {1'b0, rs[1:0]};
    do_reset();
    strap <= code;
    cyc(4);
    pg <= 1'b1;
    cyc(8);
    exp0 = {code, 5'h01};
    chk_regs();
    // Configuration is written once the straps are latched, as at system start.
    for (int i = 0; i < 4; i++) begin
      rs = xs(rs);
      d = (i == 0) ? 8'hff : (i == 1) ? 8'h00 : rs[7:0] | 8'h01;
      u_m.byte_write(8'hd2, 8'h80, d, nk);
      `CHK("wr_ack", 3'h0, nk)
      exp0 = {code, 5'h00} | (d & 8'h17);
      chk_regs();
    end
    u_m.byte_write(8'hd2, 8'h85, 8'h5a, nk);
    u_m.byte_read(8'hd2, 8'h85, rb, nk);
    `CHK("idx5", 8'h00, rb)
    chk_regs();
    rs = xs(rs);
    d = rs[7:0] | 8'h01;
    u_m.blk_write(8'hd2, 8'h01, d, nk4);
    `CHK("blkw_ack", 4'h0, nk4)
    exp0 = {code, 5'h00} | (d & 8'h17);
    chk_regs();
    u_m.blk_read(8'hd2, blk);
    `CHK("count", 8'h01, blk[0])
    `CHK("blk0", exp0, blk[1])
    `CHK("blk1", 8'h00, blk[2])
    u_m.byte_write(8'ha4, 8'h80, 8'h00, nk);
    `CHK("foreign", 3'h7, nk)
    chk_regs();
    // Writes are queued while power-down holds the drain, so the ninth must be refused.
    pg <= 1'b0;
    for (int i = 0; i < 9; i++) begin
      rs = xs(rs);
      d = rs[7:0] | 8'h01;
      u_m.byte_write(8'hd2, 8'h80, d, nk);
      `CHK("fifo_ack", pend.size() < 8 ? 1'b0 : 1'b1, nk[0])
      if (pend.size() < 8) pend.push_back(d);
    end
    `CHK("held", {exp0[4], exp0[2:0]}, {mgmt, msrc, ssel, rtn})
    cyc(1);
    pg <= 1'b1;
    cyc(40);
    exp0 = {code, 5'h00} | (pend[$] & 8'h17);
    chk_regs();
    pg <= 1'b0;
    cpu_clock_stop_n <= 1'b0;
    pci_clock_stop_n <= 1'b0;
    cyc(8);
    `CHK("mgmt_pins", 1'b1, mgmt)
    cpu_clock_stop_n <= 1'b1;
    pci_clock_stop_n <= 1'b1;
    pg <= 1'b1;
    exp0[4] = 1'b1;
    chk_regs();
    u_m.byte_write(8'hd2, 8'h80, 8'h00, nk);
    exp0 = {code, 5'h00};
    chk_regs();
    pg <= 1'b0;
    cyc(8);
    `CHK("restore", 4'h1, {mgmt, msrc, ssel, rtn})
    pg <= 1'b1;
    exp0 = {code, 5'h01};
    chk_regs();
    wrap_up();
  end
endmodule // cfgsl_top_tb
